// file: include/gpio_bcd_pkg.sv
// package: register map, field positions and carriers for the port b/c/d block
package gpio_bcd_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address on the plain port)
    // ------------------------------------------------------------------
    localparam logic [7:0] PORT_B_DATA_ADDR = 8'h01;
    localparam logic [7:0] PORT_C_DATA_ADDR = 8'h02;
    localparam logic [7:0] PORT_D_DATA_ADDR = 8'h03;
    localparam logic [7:0] PORT_B_DIR_ADDR = 8'h05;
    localparam logic [7:0] PORT_C_DIR_ADDR = 8'h06;
    localparam logic [7:0] PORT_D_DIR_ADDR = 8'h07;
    localparam logic [7:0] PERIPH_CTRL_ADDR = 8'h08;
    localparam logic [7:0] KEYPAD_IRQ_ENABLE_ADDR = 8'h09;

    // ------------------------------------------------------------------
    // field positions of the peripheral control register
    // ------------------------------------------------------------------
    localparam int SERIAL_PERIPH_ENABLE_BIT = 0;
    localparam int INFRARED_ENABLE_BIT = 1;
    localparam int SERIAL_IFACE_ENABLE_BIT = 2;
    localparam int PULLUP_DISABLE_BIT = 3;

    // ------------------------------------------------------------------
    // reset values and widths
    // ------------------------------------------------------------------
    localparam logic [7:0] DIRECTION_RESET = 8'h00;
    localparam logic [7:0] PERIPH_CTRL_RESET = 8'h00;
    localparam logic [7:0] KEYPAD_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam int PORT_WIDTH = 8;
    localparam int SYNC_STAGES = 2;

    // one port's pad-facing signals; enable low means driving
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
    } pad_drive_s;

    // peripheral overrides entering the pin mux
    typedef struct packed {
        logic [7:0] own;
        logic [7:0] out;
        logic [7:0] drive;
    } periph_ovr_s;

endpackage : gpio_bcd_pkg

// file: hw/pin_sync.sv
// two-stage synchroniser for a bus of pin levels
`timescale 1ns/1ps

module pin_sync
    import gpio_bcd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // asynchronous pins and their synchronised copy
    input wire logic [PORT_WIDTH-1:0] async_in,
    output logic [PORT_WIDTH-1:0] sync_out
);

    logic [PORT_WIDTH-1:0] meta_q;

    // ------------------------------------------------------------------
    // capture stages; first stage feeds only the second
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : pin_sync

// file: hw/gpio_ports_bcd.sv
// ports b, c and d: latches, direction, pin mux and register port
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps

// Overview of operation
// - port b data read gives latch where direction is one, else pin level
// - port c data read gives latch for outputs, pin level for inputs
// - port d data read gives latch for outputs, pin level for inputs
// - data latches accept writes whatever the direction bits hold
// - direction one drives the latched value; zero leaves pin undriven
// - reset clears port c and port d direction bits, all inputs
// - reset leaves the data latches untouched
// - writing a latch of an input pin changes only the stored bit
// - serial peripheral enable hands port c pins two to five over
// - infrared enable makes port c pins six, seven transmit and receive
// - port c pin zero always feeds the second external interrupt input
// - pin zero pull-up on unless the disable bit is set
// - port d pin is keypad interrupt input when its enable bit is set
// - ports c and d have eight pins each with latch and direction
// - serial interface enable hands port b pins two, three over
module gpio_ports_bcd
    import gpio_bcd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // pads
    input wire logic [7:0] port_b_in,
    input wire logic [7:0] port_c_in,
    input wire logic [7:0] port_d_in,
    output pad_drive_s port_b_pad,
    output pad_drive_s port_c_pad,
    output pad_drive_s port_d_pad,
    output logic pin_zero_pullup_en,
    // serial interface on port b
    input wire logic sci_transmit,
    output logic sci_receive,
    // serial peripheral interface on port c pins two to five
    input wire logic [3:0] spi_out,
    input wire logic [3:0] spi_drive,
    output logic [3:0] spi_in,
    // infrared serial interface on port c pins six and seven
    input wire logic infrared_transmit,
    output logic infrared_receive,
    // interrupt feeds
    output logic second_external_irq,
    output logic [7:0] keypad_irq_in,
    // control levels for the peripherals
    output logic serial_periph_enable,
    output logic infrared_serial_iface,
    output logic serial_iface_enable
);

    logic [7:0] port_b_latch_q;
    logic [7:0] port_c_latch_q;
    logic [7:0] port_d_latch_q;
    logic [7:0] port_b_direction_q;
    logic [7:0] port_c_direction_q;
    logic [7:0] port_d_direction_q;
    logic [7:0] ctrl_q;
    logic [7:0] keypad_irq_enable_reg_q;
    logic [7:0] b_sync;
    logic [7:0] c_sync;
    logic [7:0] d_sync;
    logic [7:0] rdata_d;
    periph_ovr_s b_ovr;
    periph_ovr_s c_ovr;
    pad_drive_s b_pad_d;
    pad_drive_s c_pad_d;
    pad_drive_s d_pad_d;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    pin_sync u_sync_b (.clk(clk), .reset(reset), .async_in(port_b_in), .sync_out(b_sync));
    pin_sync u_sync_c (.clk(clk), .reset(reset), .async_in(port_c_in), .sync_out(c_sync));
    pin_sync u_sync_d (.clk(clk), .reset(reset), .async_in(port_d_in), .sync_out(d_sync));

    // ------------------------------------------------------------------
    // data latches: no reset term, written in any direction
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (wr && addr == PORT_B_DATA_ADDR)
            port_b_latch_q <= wdata;
        if (wr && addr == PORT_C_DATA_ADDR)
            port_c_latch_q <= wdata;
        if (wr && addr == PORT_D_DATA_ADDR)
            port_d_latch_q <= wdata;
    end

    // direction registers, cleared on reset
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            port_b_direction_q <= DIRECTION_RESET;
            port_c_direction_q <= DIRECTION_RESET;
            port_d_direction_q <= DIRECTION_RESET;
        end
        else
        begin
            if (wr && addr == PORT_B_DIR_ADDR)
                port_b_direction_q <= wdata;
            if (wr && addr == PORT_C_DIR_ADDR)
                port_c_direction_q <= wdata;
            if (wr && addr == PORT_D_DIR_ADDR)
                port_d_direction_q <= wdata;
        end
    end

    // peripheral enables and keypad enables
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ctrl_q <= PERIPH_CTRL_RESET;
            keypad_irq_enable_reg_q <= KEYPAD_RESET;
        end
        else
        begin
            if (wr && addr == PERIPH_CTRL_ADDR)
                ctrl_q <= {4'h0, wdata[3:0]};
            if (wr && addr == KEYPAD_IRQ_ENABLE_ADDR)
                keypad_irq_enable_reg_q <= wdata;
        end
    end

    // ------------------------------------------------------------------
    // peripheral overrides of the pin mux
    // ------------------------------------------------------------------
    always_comb
    begin
        b_ovr = '0;
        c_ovr = '0;
        if (ctrl_q[SERIAL_IFACE_ENABLE_BIT])
        begin
            b_ovr.own[3:2] = 2'h3;
            b_ovr.out[2] = sci_transmit;
            b_ovr.drive[2] = 1'b1;
        end
        if (ctrl_q[SERIAL_PERIPH_ENABLE_BIT])
        begin
            c_ovr.own[5:2] = 4'hf;
            c_ovr.out[5:2] = spi_out;
            c_ovr.drive[5:2] = spi_drive;
        end
        if (ctrl_q[INFRARED_ENABLE_BIT])
        begin
            c_ovr.own[7:6] = 2'h3;
            c_ovr.out[6] = infrared_transmit;
            c_ovr.drive[6] = 1'b1;
        end
    end

    // per-pin mux: peripheral wins, else direction decides the driver
    always_comb
    begin
        for (int i = 0; i < PORT_WIDTH; i++)
        begin
            b_pad_d.out[i] = b_ovr.own[i] ? b_ovr.out[i] : port_b_latch_q[i];
            b_pad_d.oe_n[i] = b_ovr.own[i] ? ~b_ovr.drive[i] : ~port_b_direction_q[i];
            c_pad_d.out[i] = c_ovr.own[i] ? c_ovr.out[i] : port_c_latch_q[i];
            c_pad_d.oe_n[i] = c_ovr.own[i] ? ~c_ovr.drive[i] : ~port_c_direction_q[i];
            d_pad_d.out[i] = port_d_latch_q[i];
            d_pad_d.oe_n[i] = ~port_d_direction_q[i];
        end
    end

    // ------------------------------------------------------------------
    // read mux: latch for outputs, synchronised pin for inputs
    // ------------------------------------------------------------------
    always_comb
    begin
        unique case (addr)
            PORT_B_DATA_ADDR: rdata_d = (port_b_direction_q & port_b_latch_q) | (~port_b_direction_q & b_sync);
            PORT_C_DATA_ADDR: rdata_d = (port_c_direction_q & port_c_latch_q) | (~port_c_direction_q & c_sync);
            PORT_D_DATA_ADDR: rdata_d = (port_d_direction_q & port_d_latch_q) | (~port_d_direction_q & d_sync);
            PORT_B_DIR_ADDR: rdata_d = port_b_direction_q;
            PORT_C_DIR_ADDR: rdata_d = port_c_direction_q;
            PORT_D_DIR_ADDR: rdata_d = port_d_direction_q;
            PERIPH_CTRL_ADDR: rdata_d = ctrl_q;
            KEYPAD_IRQ_ENABLE_ADDR: rdata_d = keypad_irq_enable_reg_q;
            default: rdata_d = READ_UNMAPPED;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (reset)
            rdata <= READ_UNMAPPED;
        else if (rd)
            rdata <= rdata_d;
        else
            rdata <= READ_UNMAPPED;
    end

    // ------------------------------------------------------------------
    // registered pad and peripheral outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            port_b_pad <= '{out: 8'h00, oe_n: 8'hff};
            port_c_pad <= '{out: 8'h00, oe_n: 8'hff};
            port_d_pad <= '{out: 8'h00, oe_n: 8'hff};
        end
        else
        begin
            port_b_pad <= b_pad_d;
            port_c_pad <= c_pad_d;
            port_d_pad <= d_pad_d;
        end
    end

    // feeds to interrupt logic and peripherals; port c pin zero is never gated
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            second_external_irq <= 1'b1;
            keypad_irq_in <= 8'h00;
            pin_zero_pullup_en <= 1'b1;
            sci_receive <= 1'b1;
            spi_in <= 4'h0;
            infrared_receive <= 1'b1;
            serial_periph_enable <= 1'b0;
            infrared_serial_iface <= 1'b0;
            serial_iface_enable <= 1'b0;
        end
        else
        begin
            second_external_irq <= c_sync[0];
            keypad_irq_in <= keypad_irq_enable_reg_q & ~d_sync;
            pin_zero_pullup_en <= ~ctrl_q[PULLUP_DISABLE_BIT];
            sci_receive <= b_sync[3];
            spi_in <= c_sync[5:2];
            infrared_receive <= c_sync[7];
            serial_periph_enable <= ctrl_q[SERIAL_PERIPH_ENABLE_BIT];
            infrared_serial_iface <= ctrl_q[INFRARED_ENABLE_BIT];
            serial_iface_enable <= ctrl_q[SERIAL_IFACE_ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_dir_reset;
        @(posedge clk) reset |=> (port_c_direction_q == 8'h00 && port_d_direction_q == 8'h00);
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared by reset");

    property p_latch_write;
        @(posedge clk) disable iff (reset) (wr && addr == PORT_C_DATA_ADDR) |=> port_c_latch_q == $past(wdata);
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("port c latch missed a write");

    property p_read_b;
        @(posedge clk) disable iff (reset) (rd && addr == PORT_B_DATA_ADDR)
            |=> rdata == (($past(port_b_direction_q) & $past(port_b_latch_q)) | (~$past(port_b_direction_q) & $past(b_sync)));
    endproperty
    a_read_b: assert property (p_read_b) else $error("port b read mismatch");

    property p_read_d;
        @(posedge clk) disable iff (reset) (rd && addr == PORT_D_DATA_ADDR && port_d_direction_q == 8'h00)
            |=> rdata == $past(d_sync);
    endproperty
    a_read_d: assert property (p_read_d) else $error("port d input read mismatch");

    // pad register lags the direction register by exactly one edge
    property p_drive_d;
        @(posedge clk) disable iff (reset) 1'b1 |=> port_d_pad.oe_n == ~$past(port_d_direction_q)
            || $past(reset);
    endproperty
    a_drive_d: assert property (p_drive_d) else $error("port d driver follows wrong direction");

    property p_spi_own;
        @(posedge clk) disable iff (reset) ctrl_q[SERIAL_PERIPH_ENABLE_BIT] |=> port_c_pad.out[5:2] == $past(spi_out);
    endproperty
    a_spi_own: assert property (p_spi_own) else $error("spi pins not handed over");

    property p_ir_own;
        @(posedge clk) disable iff (reset) ctrl_q[INFRARED_ENABLE_BIT] |=> port_c_pad.oe_n[7] && !port_c_pad.oe_n[6];
    endproperty
    a_ir_own: assert property (p_ir_own) else $error("infrared pins not handed over");

    // the interrupt level must follow pin zero, whatever the pin's direction or owner
    property p_pin_zero_irq;
        @(posedge clk) disable iff (reset) 1'b1 |=> second_external_irq == $past(c_sync[0]);
    endproperty
    a_pin_zero_irq: assert property (p_pin_zero_irq) else $error("pin zero not feeding interrupt");

    property p_pullup;
        @(posedge clk) disable iff (reset) ctrl_q[PULLUP_DISABLE_BIT] |=> !pin_zero_pullup_en;
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up not disabled");

    property p_keypad;
        @(posedge clk) disable iff (reset) !keypad_irq_enable_reg_q[0] |=> !keypad_irq_in[0];
    endproperty
    a_keypad: assert property (p_keypad) else $error("keypad input active while disabled");

endmodule : gpio_ports_bcd

// file: testbench/pin_board.sv
// board model: pad resolution for ports b, c and d
`timescale 1ns/1ps

module pin_board
    import gpio_bcd_pkg::*;
(
    // pads from the block
    input wire pad_drive_s b_pad,
    input wire pad_drive_s c_pad,
    input wire pad_drive_s d_pad,
    // levels the board puts on undriven pins
    input wire logic [7:0] b_ext,
    input wire logic [7:0] c_ext,
    input wire logic [7:0] d_ext,
    // resolved pin levels back into the block
    output logic [7:0] b_pin,
    output logic [7:0] c_pin,
    output logic [7:0] d_pin
);
    // ------------------------------------------------------------
    // wire resolution
    // ------------------------------------------------------------
    // a pin whose driver is off takes the board level, never a stale one
    assign b_pin = (b_pad.oe_n & b_ext) | (~b_pad.oe_n & b_pad.out);
    assign c_pin = (c_pad.oe_n & c_ext) | (~c_pad.oe_n & c_pad.out);
    assign d_pin = (d_pad.oe_n & d_ext) | (~d_pad.oe_n & d_pad.out);
endmodule : pin_board

// file: testbench/tb_gpio_ports_bcd.sv
// self-checking bench for the port b/c/d block
`timescale 1ns/1ps

module tb_gpio_ports_bcd
    import gpio_bcd_pkg::*;
;
    // ------------------------------------------------------------
    // signals and scoreboard
    // ------------------------------------------------------------
    logic clk, reset, wr, rd, rd_seen, sci_tx, ir_tx, pu_en, sci_rx, ir_rx, pin0_irq, spi_en, ire, scie;
    logic [7:0] addr, wdata, rdata, b_pin, c_pin, d_pin, kb_irq, kbd, msk;
    logic [7:0] ext [3];
    logic [7:0] lat [3];
    logic [3:0] spi_out, spi_drive, spi_in;
    logic [1:0] p;
    logic [31:0] seed = 32'h5b2037b4;
    pad_drive_s pad [3];
    logic [7:0] exp_q [$];
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    gpio_ports_bcd dut_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .port_b_in(b_pin), .port_c_in(c_pin), .port_d_in(d_pin), .port_b_pad(pad[0]),
        .port_c_pad(pad[1]), .port_d_pad(pad[2]), .pin_zero_pullup_en(pu_en), .sci_transmit(sci_tx),
        .sci_receive(sci_rx), .spi_out(spi_out), .spi_drive(spi_drive), .spi_in(spi_in),
        .infrared_transmit(ir_tx), .infrared_receive(ir_rx), .second_external_irq(pin0_irq),
        .keypad_irq_in(kb_irq), .serial_periph_enable(spi_en), .infrared_serial_iface(ire),
        .serial_iface_enable(scie));

    pin_board board_u (.b_pad(pad[0]), .c_pad(pad[1]), .d_pad(pad[2]), .b_ext(ext[0]), .c_ext(ext[1]),
        .d_ext(ext[2]), .b_pin(b_pin), .c_pin(c_pin), .d_pin(d_pin));

    // 50 ns period
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        repeat (8) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        return s;
    endfunction : lfsr

    task automatic rnd(output logic [7:0] v);
        seed = lfsr(seed);
        v = seed[7:0];
    endtask : rnd

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_val

    // an empty queue gives 16'hdead as the expected value, which then shows as a mismatch
    task automatic cmp_read(input logic [7:0] got);
        cmp_val({8'h00, got}, exp_q.size() > 0 ? {8'h00, exp_q.pop_front()} : 16'hdead);
    endtask : cmp_read

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        exp_q.push_back(e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_reg

    // pins pass two sync flops plus a register stage
    task automatic settle;
        repeat (4) @(posedge clk);
        #1;
    endtask : settle

    // read data stand only in the cycle after the strobe
    always @(posedge clk)
    begin
        if (rd_seen)
            cmp_read(rdata);
        rd_seen <= rd;
    end

    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        reset = 1'b1;
        {wr, rd, sci_tx, ir_tx, addr, wdata, spi_out, spi_drive} = '0;
        foreach (ext[i]) ext[i] = 8'h00;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        for (p = 0; p < 3; p++) rd_reg(PORT_B_DIR_ADDR + p, 8'h00);
        settle;
        for (p = 0; p < 3; p++) cmp_val(pad[p].oe_n, 8'hff);
        for (p = 0; p < 3; p++)
        begin
            rnd(lat[p]);
            rnd(ext[p]);
            rnd(msk);
            wr_reg(PORT_B_DATA_ADDR + p, lat[p]);
            settle;
            cmp_val(pad[p].oe_n, 8'hff);
            rd_reg(PORT_B_DATA_ADDR + p, ext[p]);
            wr_reg(PORT_B_DIR_ADDR + p, msk); // latch loaded first
            settle;
            cmp_val({pad[p].oe_n, pad[p].out & msk}, {~msk, lat[p] & msk});
            rd_reg(PORT_B_DATA_ADDR + p, (lat[p] & msk) | (ext[p] & ~msk));
            rd_reg(PORT_B_DIR_ADDR + p, msk);
        end
        // reset in mid-run: directions clear, latches survive
        @(posedge clk);
        reset <= 1'b1;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        for (p = 0; p < 3; p++)
        begin
            rd_reg(PORT_B_DIR_ADDR + p, 8'h00);
            wr_reg(PORT_B_DIR_ADDR + p, 8'hff);
        end
        settle;
        for (p = 0; p < 3; p++) rd_reg(PORT_B_DATA_ADDR + p, lat[p]);
        rd_reg(8'h04, READ_UNMAPPED);
        // peripherals take pins over with every port b and port c direction bit set
        rnd(kbd);
        rnd(msk);
        rnd(ext[1]);
        spi_out <= msk[3:0];
        spi_drive <= msk[7:4];
        sci_tx <= kbd[0];
        ir_tx <= ~kbd[0];
        wr_reg(PERIPH_CTRL_ADDR, 8'hff);
        wr_reg(PORT_D_DIR_ADDR, 8'h00);
        wr_reg(KEYPAD_IRQ_ENABLE_ADDR, kbd);
        rd_reg(PERIPH_CTRL_ADDR, 8'h0f);
        settle;
        cmp_val({spi_en, ire, scie, pu_en}, 4'b1110);
        cmp_val(pad[1].oe_n, {2'b10, ~spi_drive, 2'b00});
        cmp_val({pad[1].out[6:2], pad[0].out[2], pad[0].oe_n[3:2]}, {ir_tx, spi_out, sci_tx, 2'b10});
        cmp_val({spi_in, ir_rx, pin0_irq, sci_rx},
            {(spi_drive & spi_out) | (~spi_drive & ext[1][5:2]), ext[1][7], lat[1][0], ext[0][3]});
        cmp_val(kb_irq, kbd & ~ext[2]);
        wr_reg(PERIPH_CTRL_ADDR, 8'h00);
        settle;
        cmp_val({spi_en, ire, scie, pu_en, pad[1].oe_n}, {4'b0001, 8'h00});
        repeat (3) @(posedge clk);
        conclude();
    end
endmodule : tb_gpio_ports_bcd
